// *** hw/external_wakeup_delayed_irq.sv ***
// Notes on behaviour
// - Eight independent external request channels, each with its own request line.
// - Each channel detects high, low, rising or falling per its two select bits.
// - Channels in transfer mode use only level detection, edges are ignored.
// - A channel raises its irq_lines.ext bit only when its enable bit is set; the summary status ignores the enable.
// - Each detected external request is held in a readable flag bit.
// - Select bit 0 vectors directly; 1 runs a transfer then the handler.
// - Eight wakeup inputs; a low level on any is a wakeup request.
// - All wakeup inputs share one flag.
// - Wakeup line irq_lines.wake reaches the processor only when enabled; the summary status ignores the enable.
// - A detected wakeup request is recorded in the wakeup flag.
// - Enabled wakeup ends software standby, never pin-controlled hardware standby.
// - Wakeup requests never start a transfer, only an interrupt.
// - Writing one to bit zero of the delayed register raises the request.
// - Writing zero to bit zero withdraws the delayed request.
// - The delayed request has no enable and goes straight out.
// - Delayed request state is readable in bit zero of its register.
`timescale 1ns/100ps
`include "wakeup_irq_regs.svh"
module external_wakeup_delayed_irq
  import wakeup_irq_pkg::*;
#(
  parameter int NCH = 8
)(
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Pins
  input  wire logic [NCH-1:0]   ext_req_in,
  input  wire logic [NCH-1:0]   wake_in,
  input  wire logic             hw_standby_in,
  // Processor side
  output irq_lines_s            irq_lines,
  output logic                  standby_out,
  output logic                  wakeup_out,
  // Transfer service side
  output xfer_req_s             xfer_req,
  input  wire logic             xfer_done,
  // Summary interrupt
  output logic                  irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Detection for one channel from synced current and previous samples
  function automatic logic detect(input logic [1:0] mode, input logic cur,
                                  input logic prev, input logic xfer);
    logic r;
    r = 1'b0;
    case (detect_mode_e'(mode))
      DET_LOW:  r = ~cur;
      DET_HIGH: r = cur;
      DET_RISE: r = ~xfer & cur & ~prev;
      DET_FALL: r = ~xfer & ~cur & prev;
      default:  r = 1'b0;
    endcase
    return r;
  endfunction : detect

  // Word address match for a byte offset, used by writes and by the status read
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [2*NCH-1:0]  detect_level_select_q;
  logic [NCH-1:0]    ext_req_enable_q;
  logic [NCH-1:0]    ext_req_flags_q;
  logic [NCH-1:0]    transfer_service_select_q;
  logic              wake_control_q;
  logic              wake_flag_q;
  logic              delayed_req_bit_q;
  logic              soft_standby_q;
  logic [`STAT_WIDTH-1:0] irq_status_q;
  logic [`STAT_WIDTH-1:0] irq_mask_q;
  logic [NCH-1:0]    ext_s1_q;
  logic [NCH-1:0]    ext_s2_q;
  logic [NCH-1:0]    ext_prev_q;
  logic [NCH-1:0]    wake_s1_q;
  logic [NCH-1:0]    wake_s2_q;
  logic [NCH-1:0]    handler_ok_q;
  xfer_state_e       xst_q;
  logic [2:0]        xch_q;

  // Bus handshake state
  logic              aw_held_q;
  logic              w_held_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              wr_fire;
  logic              rd_fire;
  logic [NCH-1:0]    ext_det;
  logic              wake_det;
  logic [NCH-1:0]    ext_clr;
  logic [31:0]       rd_val;
  logic              rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Two flops per pin, plus a previous-sample flop on external pins; the second and third stages feed detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_s1_q   <= '0;
      ext_s2_q   <= '0;
      ext_prev_q <= '0;
      wake_s1_q  <= '1;
      wake_s2_q  <= '1;
    end
    else
    begin
      ext_s1_q   <= ext_req_in;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      wake_s1_q  <= wake_in;
      wake_s2_q  <= wake_s1_q;
    end
  end

  // Per-channel detection, mode chosen independently
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      ext_det[i] = detect(detect_level_select_q[2*i +: 2], ext_s2_q[i],
                          ext_prev_q[i], transfer_service_select_q[i]);
    end
    wake_det = ~&wake_s2_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // Each ready only while its own half is not held and no response is out, so a second write waits for the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid
                       && !wr_fire;
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid
                       && !wr_fire;
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q[7:2] <= `OFS_IRQ_MASK >> 2) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Plain configuration written through byte lane 0 and 1
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      detect_level_select_q     <= `RST_DETECT_LEVEL;
      ext_req_enable_q          <= `RST_ZERO8;
      transfer_service_select_q <= `RST_ZERO8;
      wake_control_q            <= 1'b0;
      irq_mask_q                <= '0;
    end
    else if (wr_fire)
    begin
      if (hit(awaddr_q, `OFS_DETECT_LEVEL_SELECT))
      begin
        if (wstrb_q[0]) detect_level_select_q[7:0]  <= wdata_q[7:0];
        if (wstrb_q[1]) detect_level_select_q[15:8] <= wdata_q[15:8];
      end
      if (hit(awaddr_q, `OFS_EXT_REQ_ENABLE) && wstrb_q[0])
        ext_req_enable_q <= wdata_q[7:0];
      if (hit(awaddr_q, `OFS_TRANSFER_SELECT) && wstrb_q[0])
        transfer_service_select_q <= wdata_q[7:0];
      if (hit(awaddr_q, `OFS_WAKE_CONTROL) && wstrb_q[0])
        wake_control_q <= wdata_q[`BIT_WAKE_ENABLE];
      if (hit(awaddr_q, `OFS_IRQ_MASK))
      begin
        if (wstrb_q[0]) irq_mask_q[7:0]  <= wdata_q[7:0];
        if (wstrb_q[1]) irq_mask_q[10:8] <= wdata_q[10:8];
      end
    end
  end

  // Zero written to a flag bit clears it
  assign ext_clr = (wr_fire && hit(awaddr_q, `OFS_EXT_REQ_FLAGS) && wstrb_q[0])
                   ? ~wdata_q[7:0] : '0;

  // Request flags; a detection in the clearing cycle keeps the flag
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_req_flags_q <= '0;
      wake_flag_q     <= 1'b0;
    end
    else
    begin
      ext_req_flags_q <= (ext_req_flags_q & ~ext_clr) | ext_det;
      if (wake_det)
        wake_flag_q <= 1'b1;
      else if (wr_fire && hit(awaddr_q, `OFS_WAKE_FLAG) && wstrb_q[0]
               && !wdata_q[0])
        wake_flag_q <= 1'b0;
    end
  end

  // Delayed request: software sets and withdraws it directly
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      delayed_req_bit_q <= 1'b0;
    else if (wr_fire && hit(awaddr_q, `OFS_DELAYED_IRQ_REG) && wstrb_q[0])
      delayed_req_bit_q <= wdata_q[`BIT_DELAYED_REQ];
  end

  // Standby: software enters it, an enabled wakeup leaves it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      soft_standby_q <= 1'b0;
      wakeup_out     <= 1'b0;
    end
    else
    begin
      wakeup_out <= wake_flag_q && wake_control_q && soft_standby_q
                    && !hw_standby_in;
      if (wake_flag_q && wake_control_q && !hw_standby_in)
        soft_standby_q <= 1'b0;
      else if (wr_fire && hit(awaddr_q, `OFS_STANDBY_CONTROL) && wstrb_q[0])
        soft_standby_q <= wdata_q[`BIT_STBY_SOFT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing

  // One transfer at a time; a flagged transfer channel is served lowest first.
  // The handler line opens for that channel only after the transfer is done.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xst_q        <= ST_IDLE;
      xch_q        <= 3'h0;
      handler_ok_q <= '0;
      xfer_req     <= '0;
    end
    else
    begin
      handler_ok_q <= handler_ok_q & ext_req_flags_q; // Reopen after flag clear
      case (xst_q)
        ST_IDLE:
        begin
          for (int i = NCH - 1; i >= 0; i--)
          begin
            if (ext_req_flags_q[i] && ext_req_enable_q[i]
                && transfer_service_select_q[i] && !handler_ok_q[i])
            begin
              xch_q <= 3'(i);
              xst_q <= ST_REQ;
            end
          end
        end
        ST_REQ:
        begin
          xfer_req.valid <= 1'b1;
          xfer_req.chan  <= xch_q;
          xst_q          <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (xfer_done)
          begin
            xfer_req.valid      <= 1'b0;
            handler_ok_q[xch_q] <= 1'b1;
            xst_q               <= ST_IDLE;
          end
        end
        default: xst_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt outputs

  // Lines toward the processor interrupt controller
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_lines <= '0;
    else
    begin
      irq_lines.ext <= ext_req_flags_q & ext_req_enable_q
                       & (~transfer_service_select_q | handler_ok_q);
      irq_lines.wake    <= wake_flag_q & wake_control_q;
      irq_lines.delayed <= delayed_req_bit_q;
    end
  end

  assign standby_out = soft_standby_q;

  // Sticky summary status, cleared by reading it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_q <= '0;
    else
    begin
      irq_status_q <= ((rd_fire && hit(s_axi_araddr, `OFS_IRQ_STATUS)) ? '0 : irq_status_q)
                      | {xfer_req.valid & xfer_done, delayed_req_bit_q, wake_det, ext_det};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_q & irq_mask_q);
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  // Read mux; unmapped offsets answer SLVERR with zero data
  always_comb
  begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    case (s_axi_araddr[7:2])
      6'h00: rd_val = {16'h0, detect_level_select_q};
      6'h01: rd_val = {24'h0, ext_req_enable_q};
      6'h02: rd_val = {24'h0, ext_req_flags_q};
      6'h03: rd_val = {31'h0, wake_control_q};
      6'h04: rd_val = {31'h0, wake_flag_q};
      6'h05: rd_val = {31'h0, delayed_req_bit_q};
      6'h06: rd_val = {24'h0, transfer_service_select_q};
      6'h07: rd_val = {31'h0, soft_standby_q};
      6'h08: rd_val = {21'h0, irq_status_q};
      6'h09: rd_val = {21'h0, irq_mask_q};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule : external_wakeup_delayed_irq

// *** common/wakeup_irq_regs.svh ***
`ifndef WAKEUP_IRQ_REGS_SVH
`define WAKEUP_IRQ_REGS_SVH
// Register byte offsets
`define OFS_DETECT_LEVEL_SELECT 8'h00
`define OFS_EXT_REQ_ENABLE      8'h04
`define OFS_EXT_REQ_FLAGS       8'h08
`define OFS_WAKE_CONTROL        8'h0c
`define OFS_WAKE_FLAG           8'h10
`define OFS_DELAYED_IRQ_REG     8'h14
`define OFS_TRANSFER_SELECT     8'h18
`define OFS_STANDBY_CONTROL     8'h1c
`define OFS_IRQ_STATUS          8'h20
`define OFS_IRQ_MASK            8'h24
// Field positions
`define BIT_WAKE_ENABLE         0
`define BIT_DELAYED_REQ         0
`define BIT_STBY_SOFT           0
`define STAT_EXT_LSB            0
`define STAT_WAKE_BIT           8
`define STAT_DELAYED_BIT        9
`define STAT_XFER_DONE_BIT      10
`define STAT_WIDTH              11
// Reset values
`define RST_DETECT_LEVEL        16'h0000
`define RST_ZERO8               8'h00
`endif

// *** common/wakeup_irq_pkg.sv ***
package wakeup_irq_pkg;
  // Detection mode per channel, two bits each
  typedef enum logic [1:0] {DET_LOW, DET_HIGH, DET_RISE, DET_FALL} detect_mode_e;
  // Transfer request toward the transfer service
  typedef struct packed {
    logic       valid;
    logic [2:0] chan;
  } xfer_req_s;
  // Interrupt lines toward the processor
  typedef struct packed {
    logic [7:0] ext;
    logic       wake;
    logic       delayed;
  } irq_lines_s;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} xfer_state_e;
endpackage : wakeup_irq_pkg

// *** bench/wakeup_irq_monitor.sv ***
`timescale 1ns/100ps
module wakeup_irq_monitor
  import wakeup_irq_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Device side
  input wire logic        hw_standby_in,
  input wire irq_lines_s  irq_lines,
  input wire logic        standby_out,
  input wire logic        wakeup_out,
  input wire xfer_req_s   xfer_req,
  input wire logic        xfer_done
);
  logic       wr_fire;
  logic [2:0] done_chan_q;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////
  // Both halves of a write taken at one edge, as the bench offers them
  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Channel whose transfer just finished, kept for the handler check
  always_ff @(posedge aclk)
  begin
    if (xfer_done)
      done_chan_q <= xfer_req.chan;
  end

  ////////////////////////////////////////////////////////////////
  delayed_set_a: assert property (
    wr_fire && s_axi_awaddr == 8'h14 && s_axi_wstrb[0] && s_axi_wdata[0]
    |-> ##[1:4] irq_lines.delayed) else $error("delayed request not raised");
  delayed_clr_a: assert property (
    wr_fire && s_axi_awaddr == 8'h14 && s_axi_wstrb[0] && !s_axi_wdata[0]
    |-> ##[1:4] !irq_lines.delayed) else $error("delayed request not withdrawn");
  xfer_gate_a: assert property (
    xfer_req.valid |-> !irq_lines.ext[xfer_req.chan])
    else $error("handler raised before transfer end");
  xfer_hold_a: assert property (
    xfer_req.valid && !xfer_done |=> xfer_req.valid && $stable(xfer_req.chan))
    else $error("transfer request dropped early");
  xfer_vector_a: assert property (
    xfer_req.valid && xfer_done |-> ##[1:3] irq_lines.ext[done_chan_q])
    else $error("handler missing after transfer");
  hw_standby_a: assert property (
    standby_out && hw_standby_in |=> standby_out)
    else $error("wakeup left hardware standby");
  wake_exit_a: assert property (
    wakeup_out |-> !standby_out ##1 !wakeup_out) else $error("wakeup pulse wrong");
  rd_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (
    wr_fire |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule : wakeup_irq_monitor

bind external_wakeup_delayed_irq wakeup_irq_monitor i_mon (.*);

// *** bench/xfer_service_model.sv ***
`timescale 1ns/100ps
module xfer_service_model
  import wakeup_irq_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Request from the block, answer after a chosen lag
  input  wire xfer_req_s  xfer_req,
  input  wire logic [3:0] lag,
  output logic            xfer_done
);
  logic [3:0] cnt;

  // One done pulse per request; counter parks while the pulse is out
  always @(posedge aclk)
  begin
    xfer_done <= 1'b0;
    if (!aresetn || !xfer_req.valid || xfer_done)
      cnt <= 4'h0;
    else if (cnt == lag)
      xfer_done <= 1'b1;
    else
      cnt <= cnt + 4'h1;
  end
endmodule : xfer_service_model

// *** bench/external_wakeup_delayed_irq_bench.sv ***
`timescale 1ns/100ps
`include "wakeup_irq_regs.svh"
module external_wakeup_delayed_irq_bench
  import wakeup_irq_pkg::*;
;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, hw_standby_in, standby_out, wakeup_out, xfer_done, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ext_req_in, wake_in;
  logic [31:0] s_axi_wdata, s_axi_rdata, rng;
  logic [3:0]  s_axi_wstrb, lag;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  irq_lines_s  irq_lines;
  xfer_req_s   xfer_req;
  int          err_count = 0;
  int          checks = 0;
  logic [33:0] exp_q[$];
  logic        chk_q[$];
  logic [1:0]  bexp_q[$];

  external_wakeup_delayed_irq #(.NCH(8)) i_dut (.*);
  xfer_service_model i_xfer (.*);

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // Each half is released on the edge that takes it; the answer is awaited
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bexp_q.push_back((a > `OFS_IRQ_MASK) ? 2'h2 : 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    s_axi_bready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr

  // Expected answer is noted first; the watcher below compares it
  task automatic rd(input logic [7:0] a, input logic chk, input logic [33:0] e);
    exp_q.push_back(e);
    chk_q.push_back(chk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do
      @(posedge aclk);
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Oldest note against each read answer
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
    begin
      if (chk_q.pop_front())
        check({s_axi_rresp, s_axi_rdata}, exp_q[0]);
      void'(exp_q.pop_front());
    end
    // Write response code against the note made by the write task
    if (s_axi_bvalid && s_axi_bready && bexp_q.size() > 0)
      check(34'(s_axi_bresp), 34'(bexp_q.pop_front()));
  end

  // Cut a hang short; the whole run needs well under this
  initial
  begin
    #200us;
    err_count++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, hw_standby_in} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ext_req_in, lag} = '0;
    s_axi_wstrb = 4'hf;
    wake_in = 8'hff;
    rng = 32'd81252;
    cyc(5);
    aresetn <= 1'b1;
    cyc(2);
    rd(`OFS_DETECT_LEVEL_SELECT, 1'b1, 34'h0);
    rd(`OFS_EXT_REQ_ENABLE, 1'b1, 34'h0);
    rd(8'h28, 1'b1, {2'b10, 32'h0});
    wr(8'h28, 32'hffffffff);
    wr(`OFS_DETECT_LEVEL_SELECT, 32'hffff);
    wr(`OFS_EXT_REQ_FLAGS, 32'h0);
    rd(`OFS_EXT_REQ_FLAGS, 1'b1, 34'h0);
    repeat (4)
    begin
      rng = xs(rng);
      wr(`OFS_DELAYED_IRQ_REG, rng);
      cyc(2);
      check(34'(irq_lines.delayed), 34'(rng[0]));
      rd(`OFS_DELAYED_IRQ_REG, 1'b1, 34'(rng[0]));
    end
    wr(`OFS_DELAYED_IRQ_REG, 32'h0);
    // All four detection modes on one channel, level ones re-set after clear
    for (int m = 0; m < 4; m++)
    begin
      ext_req_in[2] <= (m == 0 || m == 3);
      cyc(6);
      wr(`OFS_DETECT_LEVEL_SELECT, 32'hffcf | (32'(m) << 4));
      wr(`OFS_EXT_REQ_FLAGS, 32'h0);
      rd(`OFS_EXT_REQ_FLAGS, 1'b1, 34'h0);
      ext_req_in[2] <= !(m == 0 || m == 3);
      cyc(6);
      rd(`OFS_EXT_REQ_FLAGS, 1'b1, 34'h4);
      wr(`OFS_EXT_REQ_FLAGS, 32'h0);
      rd(`OFS_EXT_REQ_FLAGS, 1'b1, (m > 1) ? 34'h0 : 34'h4);
    end
    // Summary interrupt: masked, unmasked, cleared by reading status
    ext_req_in[2] <= 1'b1;
    cyc(6);
    rd(`OFS_IRQ_STATUS, 1'b0, 34'h0);
    wr(`OFS_IRQ_MASK, 32'h0);
    ext_req_in[2] <= 1'b0;
    cyc(6);
    check(34'(irq), 34'h0);
    wr(`OFS_IRQ_MASK, 32'h4);
    cyc(2);
    check(34'(irq), 34'h1);
    rd(`OFS_IRQ_STATUS, 1'b1, 34'h4);
    cyc(2);
    check(34'(irq), 34'h0);
    // Enabled versus disabled channel
    wr(`OFS_DETECT_LEVEL_SELECT, 32'hfff5);
    wr(`OFS_EXT_REQ_FLAGS, 32'h0);
    wr(`OFS_EXT_REQ_ENABLE, 32'h1);
    ext_req_in[1:0] <= 2'b11;
    cyc(6);
    check(34'(irq_lines.ext), 34'h1);
    rd(`OFS_EXT_REQ_FLAGS, 1'b1, 34'h3);
    ext_req_in[1:0] <= 2'b00;
    cyc(6);
    wr(`OFS_EXT_REQ_FLAGS, 32'h0);
    cyc(2);
    check(34'(irq_lines.ext), 34'h0);
    // Every wakeup pin sets the one shared flag
    wr(`OFS_WAKE_CONTROL, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wake_in <= ~(8'h1 << i);
      cyc(6);
      check(34'(irq_lines.wake), 34'h1);
      check(34'(xfer_req.valid), 34'h0);
      wake_in <= 8'hff;
      cyc(6);
      wr(`OFS_WAKE_FLAG, 32'h0);
      rd(`OFS_WAKE_FLAG, 1'b1, 34'h0);
    end
    wr(`OFS_WAKE_CONTROL, 32'h0);
    wake_in <= 8'h7f;
    cyc(6);
    check(34'(irq_lines.wake), 34'h0);
    rd(`OFS_WAKE_FLAG, 1'b1, 34'h1);
    // Standby exit held off while the hardware standby pin is high
    hw_standby_in <= 1'b1;
    wr(`OFS_STANDBY_CONTROL, 32'h1);
    wr(`OFS_WAKE_CONTROL, 32'h1);
    cyc(4);
    check(34'(standby_out), 34'h1);
    hw_standby_in <= 1'b0;
    cyc(2);
    check(34'(wakeup_out), 34'h1);
    cyc(2);
    check(34'(standby_out), 34'h0);
    check(34'(wakeup_out), 34'h0);
    wake_in <= 8'hff;
    cyc(6);
    wr(`OFS_WAKE_FLAG, 32'h0);
    // Transfer channels: edge mode ignored, level mode runs a transfer
    wr(`OFS_DETECT_LEVEL_SELECT, 32'hf9ff);
    wr(`OFS_TRANSFER_SELECT, 32'h30);
    wr(`OFS_EXT_REQ_ENABLE, 32'h30);
    wr(`OFS_EXT_REQ_FLAGS, 32'h0);
    ext_req_in[5] <= 1'b1;
    cyc(8);
    check(34'(xfer_req.valid), 34'h0);
    for (int i = 0; i < 2; i++)
    begin
      rd(`OFS_IRQ_STATUS, 1'b0, 34'h0);
      lag <= (i == 0) ? 4'h0 : 4'h9;
      ext_req_in[4] <= 1'b1;
      for (n = 0; n < 20 && xfer_req.valid !== 1'b1; n++)
        @(posedge aclk);
      ext_req_in[4] <= 1'b0;
      check(34'(xfer_req), 34'hc);
      check(34'(irq_lines.ext[4]), 34'h0);
      for (n = 0; n < 20 && xfer_done !== 1'b1; n++)
        @(posedge aclk);
      cyc(4);
      check(34'(irq_lines.ext[4]), 34'h1);
      rd(`OFS_IRQ_STATUS, 1'b1, 34'h410);
      wr(`OFS_EXT_REQ_FLAGS, 32'h0);
      cyc(2);
      check(34'(irq_lines.ext[4]), 34'h0);
    end
    cyc(4);
    close_out();
  end
endmodule : external_wakeup_delayed_irq_bench
